// [rtl/dsw_serial_write.sv]
// Contract
// R1: Host lowers frame select before clocking.
// R2: Sample data each falling edge while selected.
// R3: Execute decoded command on 24th edge.
// R4: Host holds select low for 24 edges.
// R5: Select high or low after completion.
// R6: Host waits 100 ns before next frame.
// R7: Host keeps select high 50/33 ns.
// R8: Serial clock at most 30/20 MHz.
// R9: Bits 23-16 control, 15-0 data.
// R10: Host sends zero in bits 23,22.
// R11: Bit 20 loads A, 21 loads B.
// R12: Bit 19 is ignored.
// R13: Bit 18 selects target buffer.
// R14: Bits 17-16 are power mode.
// R15: Data goes to buffer or output.
// R16: Early select rise discards whole frame.
// R17: Output codes are straight binary 0-65535.
// R18: Select zero is A, one is B.
// R19: 00 normal, 01 1k, 10 100k, 11 hiz.
// R20: Reset clears all channel registers.
// R21: Leave power-down only by 00 load.
// R22: Shift most significant bit first.
// R23: Per channel buffer and output register.
module dsw_serial_write (
	input wire logic sys_clk_in, // System clock, 200 MHz
	input wire logic sys_rst_in, // Sync reset, active high
	input wire logic clk_en_in, // Freezes all state when low
	input wire logic frame_sel_n_in, // Frame select pin, active low
	input wire logic serial_clk_in, // Serial clock pin
	input wire logic serial_data_in, // Serial data pin
	output logic [15:0] code_a_out, // Channel A output code
	output logic [15:0] code_b_out, // Channel B output code
	output logic [1:0] pwr_mode_a_out, // Channel A power mode
	output logic [1:0] pwr_mode_b_out, // Channel B power mode
	output logic [15:0] buf_a_out, // Channel A data buffer
	output logic [15:0] buf_b_out, // Channel B data buffer
	output logic cmd_done_out // One-cycle pulse per executed command
);
	logic [2:0] pins_s;
	logic sel_n_s, sclk_s, din_s;
	logic sclk_prev_q;
	logic fall;
	logic [23:0] serial_input_word_q;
	logic [4:0] bit_cnt_q;
	logic frame_done_q;
	logic exec;
	logic [23:0] word_d;
	logic load_chan_a, load_chan_b, chan_sel;
	logic [1:0] pwr_mode;
	logic [15:0] data_val;
	logic [15:0] buf_q [2];
	logic [15:0] code_q [2];
	logic [1:0] pwr_q [2];

	dsw_sync2 #(.WIDTH(3)) u_sync (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.async_in({frame_sel_n_in, serial_clk_in, serial_data_in}),
		.sync_out(pins_s)
	);
	assign sel_n_s = pins_s[2];
	assign sclk_s = pins_s[1];
	assign din_s = pins_s[0];

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			sclk_prev_q <= 1'b0;
		end else if (clk_en_in) begin
			sclk_prev_q <= sclk_s;
		end
	end

	// Edges only count inside a frame, and none after the 24th until select goes high
	assign fall = sclk_prev_q & ~sclk_s & ~sel_n_s & ~frame_done_q; // [R2]
	assign exec = fall && (bit_cnt_q == dsw_pkg::FRAME_LAST_CNT); // [R3]
	assign word_d = {serial_input_word_q[22:0], din_s}; // [R22]

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			serial_input_word_q <= dsw_pkg::WORD_RESET;
			bit_cnt_q <= dsw_pkg::CNT_RESET;
			frame_done_q <= 1'b0;
		end else if (clk_en_in) begin
			if (sel_n_s) begin
				// Select high mid-frame drops the partial word
				serial_input_word_q <= dsw_pkg::WORD_RESET; // [R16]
				bit_cnt_q <= dsw_pkg::CNT_RESET; // [R16]
				frame_done_q <= 1'b0; // [R5]
			end else if (fall) begin
				serial_input_word_q <= word_d; // [R2]
				bit_cnt_q <= exec ? dsw_pkg::CNT_RESET : bit_cnt_q + 5'h01;
				// Holding select low afterward leaves the result alone
				frame_done_q <= exec; // [R5]
			end
		end
	end

	// Bit 19 and the reserved bits are never looked at
	assign load_chan_a = word_d[dsw_pkg::POS_LOAD_A]; // [R11] [R12]
	assign load_chan_b = word_d[dsw_pkg::POS_LOAD_B]; // [R11]
	assign chan_sel = word_d[dsw_pkg::POS_CHAN_SEL]; // [R13] [R18]
	assign pwr_mode = word_d[dsw_pkg::POS_PWR_HI:dsw_pkg::POS_PWR_LO]; // [R14] [R9]
	assign data_val = word_d[dsw_pkg::DATA_BITS-1:0]; // [R9]

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		logic sel_here;
		logic load_here;
		assign sel_here = (chan_sel == 1'(ch)); // [R18]
		assign load_here = (ch == 0) ? load_chan_a : load_chan_b;
		always_ff @(posedge sys_clk_in) begin
			if (sys_rst_in) begin
				buf_q[ch] <= dsw_pkg::CODE_RESET; // [R20]
				code_q[ch] <= dsw_pkg::CODE_RESET; // [R20]
				pwr_q[ch] <= dsw_pkg::PWR_RESET; // [R20]
			end else if (clk_en_in && exec) begin
				// Power-down frames leave buffer data intact
				if (sel_here && pwr_mode == dsw_pkg::DSW_PWR_NORMAL) begin
					buf_q[ch] <= data_val; // [R15] [R23]
				end
				if (load_here) begin
					// Selected channel takes new data in normal mode only, other takes its buffer
					if (sel_here && pwr_mode == dsw_pkg::DSW_PWR_NORMAL) begin
						code_q[ch] <= data_val; // [R15] [R17]
					end else if (!sel_here) begin
						code_q[ch] <= buf_q[ch]; // [R23]
					end
					if (sel_here) begin
						pwr_q[ch] <= pwr_mode; // [R19] [R21]
					end
				end
			end
		end
	end

	assign code_a_out = code_q[0];
	assign code_b_out = code_q[1];
	assign buf_a_out = buf_q[0];
	assign buf_b_out = buf_q[1];
	assign pwr_mode_a_out = pwr_q[0];
	assign pwr_mode_b_out = pwr_q[1];

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			cmd_done_out <= 1'b0;
		end else if (clk_en_in) begin
			cmd_done_out <= exec; // [R3]
		end
	end

	// Frame control and the shift path
	a_abort_no_change: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R16]
		(clk_en_in && sel_n_s) |=> ($stable(code_a_out) && $stable(code_b_out)
		&& $stable(pwr_mode_a_out) && $stable(pwr_mode_b_out)))
		else $error("State changed outside a frame");
	a_abort_clears: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R16]
		(clk_en_in && sel_n_s) |=> (bit_cnt_q == 5'h00 && serial_input_word_q == 24'h000000))
		else $error("Shift state not cleared on select high");
	a_done_pulse: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R3]
		(clk_en_in && exec) |=> cmd_done_out ##1 !cmd_done_out)
		else $error("Done pulse not single cycle");
	a_count_step: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R2]
		(clk_en_in && fall && !exec) |=> bit_cnt_q == $past(bit_cnt_q) + 5'h01)
		else $error("Bit count did not advance");
	a_word_shift: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R22]
		(clk_en_in && fall) |=> serial_input_word_q == $past(word_d))
		else $error("Serial word did not shift in the sampled bit");
	a_exec_count: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R3]
		(clk_en_in && exec) |=> (bit_cnt_q == 5'h00 && frame_done_q))
		else $error("Frame not closed after last bit");
	a_held_after: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R5]
		(clk_en_in && frame_done_q && !sel_n_s) |-> !fall)
		else $error("Edge taken after completed frame");
	// Held enable must leave the shift word, bit count and both output codes where they were
	a_freeze_state: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R3]
		!clk_en_in |=> ($stable(serial_input_word_q) && $stable(bit_cnt_q)
		&& $stable(code_a_out) && $stable(code_b_out)))
		else $error("State moved while enable was low");

	// Buffer writes
	a_buf_a_data: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R15]
		(clk_en_in && exec && !chan_sel && pwr_mode == 2'h0) |=> buf_a_out == $past(data_val))
		else $error("Buffer A did not take data");
	a_buf_b_data: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R15]
		(clk_en_in && exec && chan_sel && pwr_mode == 2'h0) |=> buf_b_out == $past(data_val))
		else $error("Buffer B did not take data");
	a_unsel_buf_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R13]
		(clk_en_in && exec && chan_sel) |=> $stable(buf_a_out))
		else $error("Buffer A written while B selected");
	a_pd_keeps_buf: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R14]
		(clk_en_in && exec && pwr_mode != 2'h0) |=> ($stable(buf_a_out) && $stable(buf_b_out)))
		else $error("Power-down frame altered a buffer");

	// Output register loads
	a_load_a_data: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R11]
		(clk_en_in && exec && load_chan_a && !chan_sel && pwr_mode == 2'h0)
		|=> code_a_out == $past(data_val))
		else $error("Channel A did not load data");
	a_load_b_data: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R11]
		(clk_en_in && exec && load_chan_b && chan_sel && pwr_mode == 2'h0)
		|=> code_b_out == $past(data_val))
		else $error("Channel B did not load data");
	a_a_takes_buf: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R23]
		(clk_en_in && exec && load_chan_a && chan_sel) |=> code_a_out == $past(buf_a_out))
		else $error("Channel A did not load its buffer");
	a_b_takes_buf: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R23]
		(clk_en_in && exec && load_chan_b && !chan_sel) |=> code_b_out == $past(buf_b_out))
		else $error("Channel B did not load its buffer");
	a_no_load_keep: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R23]
		(clk_en_in && exec && !load_chan_a) |=> $stable(code_a_out) && $stable(pwr_mode_a_out))
		else $error("Channel A changed without load");
	a_no_load_b: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R23]
		(clk_en_in && exec && !load_chan_b) |=> $stable(code_b_out) && $stable(pwr_mode_b_out))
		else $error("Channel B changed without load");

	// Power modes
	a_pd_set_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R19]
		(clk_en_in && exec && load_chan_a && !chan_sel) |=> pwr_mode_a_out == $past(pwr_mode))
		else $error("Channel A power mode wrong");
	a_pd_set_b: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R19]
		(clk_en_in && exec && load_chan_b && chan_sel) |=> pwr_mode_b_out == $past(pwr_mode))
		else $error("Channel B power mode wrong");
	// Only a normal-mode load aimed at A may wake it
	a_pd_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R21]
		(pwr_mode_a_out != 2'h0
		&& !(clk_en_in && exec && load_chan_a && !chan_sel && pwr_mode == 2'h0))
		|=> pwr_mode_a_out != 2'h0)
		else $error("Channel A left power-down without a load");
endmodule : dsw_serial_write

// [rtl/dsw_pkg.sv]
package dsw_pkg;
	localparam int WORD_BITS = 24;
	localparam int DATA_BITS = 16;
	localparam logic [4:0] FRAME_LAST_CNT = 5'h17;
	localparam logic [4:0] CNT_RESET = 5'h00;
	localparam logic [23:0] WORD_RESET = 24'h000000;
	localparam logic [15:0] CODE_RESET = 16'h0000;
	localparam int POS_LOAD_B = 21;
	localparam int POS_LOAD_A = 20;
	localparam int POS_CHAN_SEL = 18;
	localparam int POS_PWR_HI = 17;
	localparam int POS_PWR_LO = 16;
	localparam int SYNC_STAGES = 2;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int INTERFRAME_NS = 100;
	localparam int INTERFRAME_CYC = (INTERFRAME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	typedef enum logic [1:0] {
		DSW_PWR_NORMAL = 2'h0,
		DSW_PWR_PD_1K = 2'h1,
		DSW_PWR_PD_100K = 2'h2,
		DSW_PWR_PD_HIZ = 2'h3
	} dsw_pwr_t;
	localparam dsw_pwr_t PWR_RESET = DSW_PWR_NORMAL;
endpackage : dsw_pkg

// [rtl/dsw_sync2.sv]
module dsw_sync2 #(
	parameter int WIDTH = 3
) (
	input wire logic sys_clk_in, // System clock
	input wire logic sys_rst_in, // Sync reset, active high
	input wire logic clk_en_in, // Clock enable
	input wire logic [WIDTH-1:0] async_in, // Asynchronous pins
	output logic [WIDTH-1:0] sync_out // Synchronised levels
);
	logic [WIDTH-1:0] meta_q;
	// Stage one feeds only stage two
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			meta_q <= '0;
			sync_out <= '0;
		end else if (clk_en_in) begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : dsw_sync2

// [tb/dsw_host_model.sv]
module dsw_host_model (
	input wire logic sys_clk_in, // Pacing clock
	output logic frame_sel_n_out, // Frame select, active low
	output logic serial_clk_out, // Serial clock, idle high
	output logic serial_data_out // Serial data, MSB first
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		frame_sel_n_out = 1'b1;
		serial_clk_out = 1'b1;
		serial_data_out = 1'b0;
	end
	// 40 ns half period gives an 80 ns serial clock
	task automatic half;
		repeat (8) @(negedge sys_clk_in);
	endtask : half
	task automatic pulse(input logic bit_v);
		serial_data_out = bit_v;
		half();
		serial_clk_out = 1'b0;
		half();
		serial_clk_out = 1'b1;
	endtask : pulse
	// Sends n bits of w; extra clocks after the word when keep is set
	task automatic send(input logic [23:0] w, input int n, input bit keep);
		frame_sel_n_out = 1'b0;
		half();
		for (int i = 23; i > 23 - n; i--) begin
			pulse(w[i]);
		end
		if (keep) begin
			repeat (3) pulse(~serial_data_out);
		end
		// Released data line shows the inverse, not a stale copy
		serial_data_out = ~serial_data_out;
		half();
		frame_sel_n_out = 1'b1;
		repeat (4) half();
	endtask : send
endmodule : dsw_host_model

// [tb/dsw_serial_write_tb_top.sv]
module dsw_serial_write_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic clk_en = 1'b1;
	logic fs_n, sck, sdi, done;
	logic [15:0] ca, cb, ba, bb;
	logic [1:0] pa, pb;
	int n_fail = 0;
	int checks = 0;
	int n_done = 0;
	int cyc = 0;
	always #2.5 sys_clk_in = ~sys_clk_in;
	dsw_host_model host (.sys_clk_in(sys_clk_in), .frame_sel_n_out(fs_n),
		.serial_clk_out(sck), .serial_data_out(sdi));
	dsw_serial_write DUT (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en),
		.frame_sel_n_in(fs_n), .serial_clk_in(sck), .serial_data_in(sdi), .code_a_out(ca),
		.code_b_out(cb), .pwr_mode_a_out(pa), .pwr_mode_b_out(pb), .buf_a_out(ba),
		.buf_b_out(bb), .cmd_done_out(done));
	// Sampled away from the launching edge
	always @(negedge sys_clk_in) begin
		if (done === 1'b1) n_done++;
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	task automatic t_buf;
		chk(ca | cb | ba | bb | {12'h000, pa, pb}, 16'h0000);
		host.send(24'h001234, 24, 1'b0);
		chk(ba, 16'h1234);
		chk(ca, 16'h0000);
		$display("test buffer done");
	endtask : t_buf
	task automatic t_load;
		host.send(24'h3CABCD, 24, 1'b0);
		chk(bb, 16'hABCD);
		chk(cb, 16'hABCD);
		chk(ca, 16'h1234);
		chk(16'(n_done), 16'h0002);
		$display("test load done");
	endtask : t_load
	task automatic t_pwr;
		for (int m = 1; m < 4; m++) begin
			host.send({6'h04, m[1:0], 16'hFFFF}, 24, 1'b0);
			chk({14'h0000, pa}, 16'(m));
			chk(ca, 16'h1234);
			chk(ba, 16'h1234);
			chk({14'h0000, pb}, 16'h0000);
		end
		host.send(24'h100F0F, 24, 1'b0);
		chk({14'h0000, pa}, 16'h0000);
		chk(ca, 16'h0F0F);
		$display("test power done");
	endtask : t_pwr
	task automatic t_abort;
		int d0;
		d0 = n_done;
		host.send(24'h24FFFF, 12, 1'b0);
		chk(cb, 16'hABCD);
		chk(16'(n_done), 16'(d0));
		host.send(24'h240001, 24, 1'b0);
		chk(cb, 16'h0001);
		host.send(24'h24FFFF, 24, 1'b1);
		chk(cb, 16'hFFFF);
		chk(16'(n_done), 16'(d0 + 2));
		$display("test abort done");
	endtask : t_abort
	task automatic t_freeze;
		clk_en = 1'b0;
		host.send(24'h10AAAA, 24, 1'b0);
		chk(ca, 16'h0F0F);
		chk(ba, 16'h0F0F);
		clk_en = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		chk(ca, 16'h0F0F);
		$display("test freeze done");
	endtask : t_freeze
	task automatic t_reset;
		sys_rst_in = 1'b1;
		repeat (5) @(negedge sys_clk_in);
		sys_rst_in = 1'b0;
		chk(ca | cb | ba | bb | {12'h000, pa, pb}, 16'h0000);
		host.send(24'h30BEEF, 24, 1'b0);
		chk(ca, 16'hBEEF);
		chk(ba, 16'hBEEF);
		chk(cb, 16'h0000);
		$display("test reset done");
	endtask : t_reset
	initial begin
		repeat (5) @(negedge sys_clk_in);
		sys_rst_in = 1'b0;
		repeat (4) @(negedge sys_clk_in);
		t_buf();
		t_load();
		t_pwr();
		t_abort();
		t_freeze();
		t_reset();
		give_verdict();
	end
endmodule : dsw_serial_write_tb_top
